/* File: verilog/fskc_defs.svh */
// Constants for the caller identification FSK sequencer.
// Assumes a 40 MHz core clock and a byte-wide host command port.
`ifndef FSKC_DEFS_SVH
`define FSKC_DEFS_SVH

// ==========================================================
// Register indices on the host command port
`define FSKC_ADDR_FLAG 6'h13
`define FSKC_ADDR_BYTES 6'h14
`define FSKC_ADDR_SEIZE 6'h15
`define FSKC_ADDR_MARK 6'h16
`define FSKC_ADDR_CTRL 6'h17

// ==========================================================
// Control register fields
`define FSKC_CTL_LAUNCH 0
`define FSKC_CTL_HOLD 1
`define FSKC_CTL_STD 2
`define FSKC_CTL_EN 3
`define FSKC_CTL_CS_LO 4
`define FSKC_CTL_CS_HI 5
`define FSKC_RST_BYTE 8'h00
`define FSKC_RST_BIT 1'b0
`define FSKC_RST_CS 2'h0

// ==========================================================
// Data store and line symbols
`define FSKC_STORE_DEPTH 64
`define FSKC_MAX_BYTES 8'h40
`define FSKC_DATA_LAST 9'h007
`define FSKC_START_BIT 1'b0
`define FSKC_STOP_BIT 1'b1
`define FSKC_MARK_BIT 1'b1

// ==========================================================
// Timing and tones
`define FSKC_CLK_HZ 40000000
`define FSKC_BAUD_RATE 1200
`define FSKC_BELL_MARK_HZ 1200
`define FSKC_BELL_SPACE_HZ 2200
`define FSKC_V23_MARK_HZ 1300
`define FSKC_V23_SPACE_HZ 2100
`define FSKC_ACC_W 24

`endif

/* File: verilog/fskc_pkg.sv */
// Types shared by the caller identification FSK sequencer files.
// Assumes fskc_defs.svh is on the include path.
package fskc_pkg;

	// ==========================================================
	// Sequencer states, also used to tag each line bit
	typedef enum logic [2:0] {
		FSKC_IDLE,
		FSKC_SEIZE,
		FSKC_MARK,
		FSKC_START,
		FSKC_DATA,
		FSKC_STOP,
		FSKC_FLAG,
		FSKC_DRAIN
	} fskc_state_type;

	// ==========================================================
	// One line bit on its way to the modulator
	typedef struct packed {
		fskc_state_type part;
		logic lineBit;
	} fskc_sym_type;

	// ==========================================================
	// One host command: register or store access
	typedef struct packed {
		logic write;
		logic toStore;
		logic [5:0] addr;
		logic [7:0] data;
	} fskc_cmd_type;

endpackage : fskc_pkg

/* File: verilog/fskc_bit_buffer.sv */
// Two-entry buffer between the sequencer and the modulator.
// Assumes one clock; flush drops both entries.
`timescale 1ns/1ps
`default_nettype none

module fskc_bit_buffer
	import fskc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic flush,
	input wire logic inValid,
	input wire fskc_sym_type inSym,
	output logic inReady,
	output logic outValid,
	input wire logic outReady,
	output fskc_sym_type outSym
);

	fskc_sym_type slot_ff [0:1];
	logic wrPtr_ff;
	logic rdPtr_ff;
	logic [1:0] count_ff;
	logic doPush;
	logic doPop;

	assign inReady = (count_ff != 2'h2) && !flush;
	assign outValid = (count_ff != 2'h0) && !flush;
	assign outSym = slot_ff[rdPtr_ff];
	assign doPush = inValid && inReady;
	assign doPop = outValid && outReady;

	always_ff @(posedge clock) begin
		if (ce && doPush) begin
			slot_ff[wrPtr_ff] <= inSym;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wrPtr_ff <= 1'b0;
			rdPtr_ff <= 1'b0;
			count_ff <= 2'h0;
		end else if (ce) begin
			if (flush) begin
				wrPtr_ff <= 1'b0;
				rdPtr_ff <= 1'b0;
				count_ff <= 2'h0;
			end else begin
				wrPtr_ff <= wrPtr_ff ^ doPush;
				rdPtr_ff <= rdPtr_ff ^ doPop;
				count_ff <= count_ff + {1'b0, doPush} - {1'b0, doPop};
			end
		end
	end

endmodule : fskc_bit_buffer

`default_nettype wire

/* File: verilog/fskc_tone.sv */
// Baud timer and phase-accumulator tone generator.
// Assumes one bit is offered per baud period by a valid/ready source.
`timescale 1ns/1ps
`default_nettype none
`include "fskc_defs.svh"

module fskc_tone
	import fskc_pkg::*;
#(
	parameter int BAUD_CYCLES = `FSKC_CLK_HZ / `FSKC_BAUD_RATE
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic enable,
	input wire logic stdSel,
	input wire logic holdOnes,
	input wire logic symValid,
	input wire fskc_sym_type sym,
	output logic symReady,
	output logic busy,
	output logic toneLevel,
	output logic toneOn
);

	logic [15:0] baudCnt_ff;
	logic bitActive_ff;
	logic curBit_ff;
	logic [`FSKC_ACC_W-1:0] acc_ff;
	logic lastCycle;
	logic sendBit;
	logic nxtOn;
	logic [`FSKC_ACC_W-1:0] inc;

	function automatic logic [`FSKC_ACC_W-1:0] freqInc(input longint hz);
		longint q;
		q = (hz << `FSKC_ACC_W) / `FSKC_CLK_HZ;
		freqInc = q[`FSKC_ACC_W-1:0];
	endfunction : freqInc

	assign lastCycle = (baudCnt_ff == 16'(BAUD_CYCLES - 1));
	assign symReady = enable && (!bitActive_ff || lastCycle);
	assign busy = bitActive_ff;

	// ==========================================================
	// Baud timing: one line bit per period
	// 1200 baud pacing
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			baudCnt_ff <= 16'h0000;
			bitActive_ff <= 1'b0;
			curBit_ff <= `FSKC_MARK_BIT;
		end else if (ce) begin
			if (!enable) begin
				bitActive_ff <= 1'b0;
				baudCnt_ff <= 16'h0000;
			end else if (symReady) begin
				bitActive_ff <= symValid;
				curBit_ff <= sym.lineBit;
				baudCnt_ff <= 16'h0000;
			end else begin
				baudCnt_ff <= baudCnt_ff + 16'h0001;
			end
		end
	end

	// ==========================================================
	// Tone selection and accumulator
	// ones hold after send
	assign sendBit = bitActive_ff ? curBit_ff : `FSKC_MARK_BIT;
	assign nxtOn = enable && (bitActive_ff || holdOnes);

	always_comb begin
		if (stdSel) begin
			inc = sendBit ? freqInc(`FSKC_V23_MARK_HZ) : freqInc(`FSKC_V23_SPACE_HZ);
		end else begin
			inc = sendBit ? freqInc(`FSKC_BELL_MARK_HZ) : freqInc(`FSKC_BELL_SPACE_HZ);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_ff <= '0;
			toneOn <= 1'b0;
			toneLevel <= 1'b0;
		end else if (ce) begin
			toneOn <= nxtOn;
			acc_ff <= nxtOn ? acc_ff + inc : '0;
			toneLevel <= nxtOn && acc_ff[`FSKC_ACC_W-1];
		end
	end

endmodule : fskc_tone

`default_nettype wire

/* File: verilog/fskc_sequencer.sv */
// Caller identification FSK sequencer: registers, data store, framing.
// Assumes a host command port taking one request per cycle and
// four voice channel inputs that accept a routed tone level.
`timescale 1ns/1ps
`default_nettype none
`include "fskc_defs.svh"

// Overview of operation
// - Seizure zero-one pairs are sent first
// - Mark run of ones follows seizure
// - Each byte: start, eight bits, stop, flag
// - Repeat bytes until count done, then end
// - Launch bit starts; hardware clears at end
// - After send, hold ones or mute
// - Hold not resumed until next launch
// - Bytes go onto the line LSB first
// - Flag run length from 8-bit field
// - Byte count 0 to 64, 64-byte store
// - Seizure lasts twice the pair count
// - Mark run length from 8-bit field
// - Standard bit picks Bell or V.23 tones
// - Enable bit turns modulator on or off
// - Two-bit select routes to one channel
// - 1200 baud with standard mark/space tones
module fskc_sequencer
	import fskc_pkg::*;
#(
	parameter int BAUD_CYCLES = `FSKC_CLK_HZ / `FSKC_BAUD_RATE
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic cmdValid,
	input wire fskc_cmd_type cmd,
	output logic rdValid,
	output logic [7:0] rdData,
	output logic [3:0] chanTone,
	output logic [3:0] chanActive,
	output logic txRunning
);

	// ==========================================================
	// Registers and store
	logic [7:0] flagLen_ff;
	logic [7:0] byteCount_ff;
	logic [7:0] seizePairs_ff;
	logic [7:0] markLen_ff;
	logic launch_ff;
	logic holdBit_ff;
	logic stdSel_ff;
	logic modEn_ff;
	logic [1:0] chanSel_ff;
	logic [7:0] store_ff [0:`FSKC_STORE_DEPTH-1];

	// ==========================================================
	// Sequencer state
	fskc_state_type state_ff;
	fskc_state_type nxt_state;
	logic [8:0] cnt_ff;
	logic [6:0] byteIdx_ff;
	logic [7:0] shift_ff;
	logic postSend_ff;
	logic holdArm_ff;

	logic regWr;
	logic ctrlWr;
	logic startNow;
	logic seqDone;
	logic lastBit;
	logic symPush;
	logic [7:0] cntEff;
	logic [7:0] ctrlView;
	logic [7:0] rdMux;
	fskc_state_type afterMark;
	fskc_state_type afterSeize;
	fskc_state_type afterFlag;
	fskc_state_type afterStop;

	fskc_sym_type pushSym;
	logic pushValid;
	logic pushReady;
	fskc_sym_type lineSym;
	logic lineValid;
	logic lineReady;
	logic toneBusy;
	logic lineBusy;
	logic holdOnes;
	logic toneLevel;
	logic toneOn;

	function automatic logic [7:0] clampCount(input logic [7:0] n);
		clampCount = (n > `FSKC_MAX_BYTES) ? `FSKC_MAX_BYTES : n;
	endfunction : clampCount

	assign regWr = cmdValid && cmd.write && !cmd.toStore;
	assign ctrlWr = regWr && (cmd.addr == `FSKC_ADDR_CTRL);
	assign cntEff = clampCount(byteCount_ff);

	// ==========================================================
	// Configuration registers
	// flag length field
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flagLen_ff <= `FSKC_RST_BYTE;
			byteCount_ff <= `FSKC_RST_BYTE;
			seizePairs_ff <= `FSKC_RST_BYTE;
			markLen_ff <= `FSKC_RST_BYTE;
			holdBit_ff <= `FSKC_RST_BIT;
			stdSel_ff <= `FSKC_RST_BIT;
			modEn_ff <= `FSKC_RST_BIT;
			chanSel_ff <= `FSKC_RST_CS;
		end else if (ce && regWr) begin
			case (cmd.addr)
				`FSKC_ADDR_FLAG: flagLen_ff <= cmd.data;
				`FSKC_ADDR_BYTES: byteCount_ff <= cmd.data;
				`FSKC_ADDR_SEIZE: seizePairs_ff <= cmd.data;
				`FSKC_ADDR_MARK: markLen_ff <= cmd.data;
				`FSKC_ADDR_CTRL: begin
					holdBit_ff <= cmd.data[`FSKC_CTL_HOLD];
					stdSel_ff <= cmd.data[`FSKC_CTL_STD];
					modEn_ff <= cmd.data[`FSKC_CTL_EN];
					chanSel_ff <= cmd.data[`FSKC_CTL_CS_HI:`FSKC_CTL_CS_LO];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			launch_ff <= `FSKC_RST_BIT;
		end else if (ce) begin
			if (ctrlWr) begin
				launch_ff <= cmd.data[`FSKC_CTL_LAUNCH];
			end else if (seqDone || !modEn_ff) begin
				launch_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (ce && cmdValid && cmd.write && cmd.toStore) begin
			store_ff[cmd.addr] <= cmd.data;
		end
	end

	// ==========================================================
	// Read answers, one cycle after the request
	always_comb begin
		ctrlView = 8'h00;
		ctrlView[`FSKC_CTL_LAUNCH] = launch_ff;
		ctrlView[`FSKC_CTL_HOLD] = holdBit_ff;
		ctrlView[`FSKC_CTL_STD] = stdSel_ff;
		ctrlView[`FSKC_CTL_EN] = modEn_ff;
		ctrlView[`FSKC_CTL_CS_HI:`FSKC_CTL_CS_LO] = chanSel_ff;
		if (cmd.toStore) begin
			rdMux = store_ff[cmd.addr];
		end else begin
			case (cmd.addr)
				`FSKC_ADDR_FLAG: rdMux = flagLen_ff;
				`FSKC_ADDR_BYTES: rdMux = byteCount_ff;
				`FSKC_ADDR_SEIZE: rdMux = seizePairs_ff;
				`FSKC_ADDR_MARK: rdMux = markLen_ff;
				`FSKC_ADDR_CTRL: rdMux = ctrlView;
				default: rdMux = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdValid <= 1'b0;
			rdData <= 8'h00;
		end else if (ce) begin
			rdValid <= cmdValid && !cmd.write;
			if (cmdValid && !cmd.write) begin
				rdData <= rdMux;
			end
		end
	end

	// ==========================================================
	// Message framing
	// mark run after seizure
	assign afterMark = (cntEff != 8'h00) ? FSKC_START : FSKC_DRAIN;
	assign afterSeize = (markLen_ff != 8'h00) ? FSKC_MARK : afterMark;
	assign afterFlag = ({1'b0, byteIdx_ff} < cntEff) ? FSKC_START : FSKC_DRAIN;
	assign afterStop = (flagLen_ff != 8'h00) ? FSKC_FLAG : afterFlag;

	assign startNow = (state_ff == FSKC_IDLE) && launch_ff && modEn_ff;
	assign seqDone = (state_ff == FSKC_DRAIN) && !lineBusy && modEn_ff;
	assign symPush = pushValid && pushReady;
	assign lineBusy = lineValid || toneBusy;
	assign txRunning = (state_ff != FSKC_IDLE);

	always_comb begin
		pushValid = 1'b1;
		pushSym.part = state_ff;
		pushSym.lineBit = `FSKC_MARK_BIT;
		lastBit = 1'b0;
		case (state_ff)
			FSKC_SEIZE: begin
				pushSym.lineBit = cnt_ff[0];
				lastBit = (cnt_ff == {seizePairs_ff - 8'h01, 1'b1});
			end
			FSKC_MARK: lastBit = (cnt_ff == {1'b0, markLen_ff - 8'h01});
			FSKC_START: begin
				pushSym.lineBit = `FSKC_START_BIT;
				lastBit = 1'b1;
			end
			FSKC_DATA: begin
				pushSym.lineBit = shift_ff[0];
				lastBit = (cnt_ff == `FSKC_DATA_LAST);
			end
			FSKC_STOP: begin
				pushSym.lineBit = `FSKC_STOP_BIT;
				lastBit = 1'b1;
			end
			FSKC_FLAG: lastBit = (cnt_ff == {1'b0, flagLen_ff - 8'h01});
			default: pushValid = 1'b0;
		endcase
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			FSKC_IDLE: begin
				if (startNow) begin
					nxt_state = (seizePairs_ff != 8'h00) ? FSKC_SEIZE : afterSeize;
				end
			end
			FSKC_SEIZE: nxt_state = afterSeize;
			FSKC_MARK: nxt_state = afterMark;
			FSKC_START: nxt_state = FSKC_DATA;
			FSKC_DATA: nxt_state = FSKC_STOP;
			FSKC_STOP: nxt_state = afterStop;
			FSKC_FLAG: nxt_state = afterFlag;
			FSKC_DRAIN: begin
				if (!lineBusy) begin
					nxt_state = FSKC_IDLE;
				end
			end
			default: nxt_state = FSKC_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff <= FSKC_IDLE;
			cnt_ff <= 9'h000;
			byteIdx_ff <= 7'h00;
			shift_ff <= 8'h00;
		end else if (ce) begin
			if (!modEn_ff) begin
				state_ff <= FSKC_IDLE;
				cnt_ff <= 9'h000;
			end else if (startNow) begin
				state_ff <= nxt_state;
				cnt_ff <= 9'h000;
				byteIdx_ff <= 7'h00;
			end else if (state_ff == FSKC_DRAIN) begin
				state_ff <= nxt_state;
			end else if (symPush) begin
				if (state_ff == FSKC_START) begin
					shift_ff <= store_ff[byteIdx_ff[5:0]];
					byteIdx_ff <= byteIdx_ff + 7'h01;
				end else if (state_ff == FSKC_DATA) begin
					shift_ff <= {1'b0, shift_ff[7:1]};
				end
				if (lastBit) begin
					state_ff <= nxt_state;
					cnt_ff <= 9'h000;
				end else begin
					cnt_ff <= cnt_ff + 9'h001;
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			postSend_ff <= 1'b0;
			holdArm_ff <= 1'b0;
		end else if (ce) begin
			if (startNow) begin
				postSend_ff <= 1'b0;
				holdArm_ff <= 1'b1;
			end else begin
				postSend_ff <= postSend_ff || seqDone;
				holdArm_ff <= holdArm_ff && holdBit_ff;
			end
		end
	end

	// Done cycle included so the carrier does not drop between message and hold
	assign holdOnes = (postSend_ff || seqDone) && holdArm_ff && holdBit_ff;

	// ==========================================================
	// Line path: buffer then modulator
	fskc_bit_buffer u_buffer (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.flush(!modEn_ff),
		.inValid(pushValid),
		.inSym(pushSym),
		.inReady(pushReady),
		.outValid(lineValid),
		.outReady(lineReady),
		.outSym(lineSym)
	);

	fskc_tone #(
		.BAUD_CYCLES(BAUD_CYCLES)
	) u_tone (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.enable(modEn_ff),
		.stdSel(stdSel_ff),
		.holdOnes(holdOnes),
		.symValid(lineValid),
		.sym(lineSym),
		.symReady(lineReady),
		.busy(toneBusy),
		.toneLevel(toneLevel),
		.toneOn(toneOn)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			chanTone <= 4'h0;
			chanActive <= 4'h0;
		end else if (ce) begin
			for (int i = 0; i < 4; i++) begin
				chanActive[i] <= toneOn && (chanSel_ff == 2'(i));
				chanTone[i] <= toneLevel && (chanSel_ff == 2'(i));
			end
		end
	end

endmodule : fskc_sequencer

`default_nettype wire

/* File: bench/fskc_sequencer_checker.sv */
// Port checker for the FSK sequencer.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "fskc_defs.svh"
module fskc_sequencer_checker
	import fskc_pkg::*;
#(
	parameter int BAUD_CYCLES = 20
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic cmdValid,
	input wire fskc_cmd_type cmd,
	input wire logic rdValid,
	input wire logic [7:0] rdData,
	input wire logic [3:0] chanTone,
	input wire logic [3:0] chanActive,
	input wire logic txRunning
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic ctlWr;
	logic [31:0] runLen_ff;
	assign ctlWr = ce && cmdValid && cmd.write && !cmd.toStore && cmd.addr == `FSKC_ADDR_CTRL;
	// ====
	// Length of the current tone burst
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			runLen_ff <= 32'h0;
		else if (|chanActive)
			runLen_ff <= runLen_ff + 32'h1;
		else
			runLen_ff <= 32'h0;
	end
	sequence sRead;
		ce && cmdValid && !cmd.write;
	endsequence
	sequence sLaunch;
		ctlWr && cmd.data[`FSKC_CTL_LAUNCH] && !txRunning;
	endsequence
	// ====
	// Assertions
	AST_RD_ANSWER: assert property (sRead |=> rdValid) // read answered
		else $error("read not answered");
	AST_RD_STABLE: assert property (!rdValid |-> $stable(rdData)) // data held
		else $error("read data moved");
	AST_ONE_CHANNEL: assert property ($onehot0(chanActive)) // one channel
		else $error("several channels active");
	AST_SILENT: assert property (chanActive == 4'h0 && $past(chanActive) == 4'h0 // silent
		&& $past(chanActive, 2) == 4'h0 && !$past(ctlWr) && !$past(ctlWr, 2)
		|-> $stable(chanTone))
		else $error("tone while silent");
	AST_ACTIVE_RUN: assert property ($rose(|chanActive) |-> $past(txRunning)) // needs launch
		else $error("tone without sequence");
	AST_MIN_BIT: assert property ($fell(|chanActive) |-> runLen_ff >= BAUD_CYCLES) // bit time
		else $error("burst shorter than one bit");
	AST_LAUNCH: assert property (sLaunch ##0 cmd.data[`FSKC_CTL_EN] |-> ##[1:3] txRunning) // starts
		else $error("launch did not start");
	AST_LAUNCH_OFF: assert property (sLaunch ##0 !cmd.data[`FSKC_CTL_EN] |=> (!txRunning)[*4]) // off
		else $error("launch ran while disabled");
	AST_ABORT: assert property (ctlWr && !cmd.data[`FSKC_CTL_EN] // generator off
		|-> ##[1:6] (!txRunning && chanActive == 4'h0))
		else $error("disable did not stop output");
endmodule : fskc_sequencer_checker
bind fskc_sequencer fskc_sequencer_checker #(.BAUD_CYCLES(BAUD_CYCLES)) fskc_sequencer_checker_inst (
	.clock(clock), .rst(rst), .ce(ce), .cmdValid(cmdValid), .cmd(cmd), .rdValid(rdValid),
	.rdData(rdData), .chanTone(chanTone), .chanActive(chanActive), .txRunning(txRunning));
`default_nettype wire

/* File: bench/fskc_line_receiver.sv */
// Line side receiver model: measures tone bursts and tone half periods.
// Assumes the routed channel outputs of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module fskc_line_receiver (
	input wire logic clock,
	input wire logic [3:0] chanTone,
	input wire logic [3:0] chanActive,
	output logic burstDone,
	output logic [31:0] burstLen,
	output logic [3:0] burstChan,
	output logic [31:0] halfLen,
	output logic [7:0] edgeCnt
);
	logic [31:0] run;
	logic [31:0] sinceEdge;
	logic [3:0] prevTone;
	initial begin
		burstDone = 1'b0;
		run = 32'h0;
		sinceEdge = 32'h0;
		edgeCnt = 8'h00;
		halfLen = 32'h0;
		burstLen = 32'h0;
		burstChan = 4'h0;
		prevTone = 4'h0;
	end
	always @(posedge clock) begin
		burstDone <= 1'b0;
		prevTone <= chanTone;
		if (chanActive != 4'h0) begin
			run <= run + 32'h1;
			burstChan <= chanActive;
			sinceEdge <= sinceEdge + 32'h1;
			if (((chanTone ^ prevTone) & chanActive) != 4'h0) begin
				halfLen <= sinceEdge;
				edgeCnt <= edgeCnt + 8'h01;
				sinceEdge <= 32'h1;
			end
		end else if (run != 32'h0) begin
			burstDone <= 1'b1;
			burstLen <= run;
			run <= 32'h0;
			edgeCnt <= 8'h00;
			sinceEdge <= 32'h0;
		end
	end
endmodule : fskc_line_receiver
`default_nettype wire

/* File: bench/fskc_sequencer_tb.sv */
// Self-checking bench for the FSK sequencer.
// Assumes the receiver model and the checker bind are compiled with it.
`timescale 1ns/1ps
`default_nettype none
`include "fskc_defs.svh"
module fskc_sequencer_tb;
	import fskc_pkg::*;
	localparam int BC = 20;
	logic clock, rst, ce, cmdValid, rdValid, txRunning, burstDone;
	fskc_cmd_type cmd;
	logic [7:0] rdData, edgeCnt, i;
	logic [3:0] chanTone, chanActive, burstChan;
	logic [31:0] burstLen, halfLen, seed, v, e;
	logic [7:0] store [64];
	logic [7:0] rq [$];
	logic [31:0] bq [$];
	int n_fail, samples_checked, k;
	fskc_sequencer #(.BAUD_CYCLES(BC)) fskc_sequencer_inst (.clock(clock), .rst(rst), .ce(ce),
		.cmdValid(cmdValid), .cmd(cmd), .rdValid(rdValid), .rdData(rdData),
		.chanTone(chanTone), .chanActive(chanActive), .txRunning(txRunning));
	fskc_line_receiver fskc_line_receiver_inst (.clock(clock), .chanTone(chanTone),
		.chanActive(chanActive), .burstDone(burstDone), .burstLen(burstLen),
		.burstChan(burstChan), .halfLen(halfLen), .edgeCnt(edgeCnt));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got,
		input int tol);
		logic bad;
		bad = (got !== exp);
		if (tol > 0 && !$isunknown(got))
			bad = (got + 32'(tol) - exp) > 32'(2 * tol);
		samples_checked++;
		if (bad) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk
	task automatic req(input logic w, input logic s, input logic [5:0] a, input logic [7:0] d);
		@(negedge clock);
		cmdValid = 1'b1;
		cmd = {w, s, a, d};
		@(negedge clock);
		cmdValid = 1'b0;
	endtask : req
	task automatic rd(input logic s, input logic [5:0] a, input logic [7:0] exp);
		rq.push_back(exp);
		req(1'b0, s, a, 8'h00);
	endtask : rd
	task automatic waitIdle();
		int n;
		n = 0;
		repeat (4) @(negedge clock);
		while (txRunning !== 1'b0 && n < 20000) begin
			@(negedge clock);
			n++;
		end
		if (n >= 20000)
			chk("idle wait", 32'h0, 32'h1, 0); // sequence ends
		repeat (6) @(negedge clock);
	endtask : waitIdle
	task automatic send(input logic [1:0] ch, input logic std, input logic [7:0] s,
		input logic [7:0] m, input logic [7:0] n, input logic [7:0] f);
		logic [31:0] nb;
		nb = (n > `FSKC_MAX_BYTES) ? 32'h40 : {24'h0, n};
		req(1'b1, 1'b0, `FSKC_ADDR_FLAG, f);
		req(1'b1, 1'b0, `FSKC_ADDR_BYTES, n);
		req(1'b1, 1'b0, `FSKC_ADDR_SEIZE, s);
		req(1'b1, 1'b0, `FSKC_ADDR_MARK, m);
		bq.push_back({4'h1 << ch, 28'(BC * (2 * s + m + nb * (10 + f)))});
		req(1'b1, 1'b0, `FSKC_ADDR_CTRL, {2'b00, ch, 1'b1, std, 2'b01});
		rd(1'b0, `FSKC_ADDR_CTRL, {2'b00, ch, 1'b1, std, 2'b01}); // launch stays set
		waitIdle();
		rd(1'b0, `FSKC_ADDR_CTRL, {2'b00, ch, 1'b1, std, 2'b00}); // launch cleared
	endtask : send
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	// ====
	// Result monitor
	always @(negedge clock) begin
		if (rdValid === 1'b1) begin
			if (rq.size() == 0)
				chk("read surplus", 32'h0, 32'h1, 0); // no extra answer
			else
				chk("read data", {24'h0, rq.pop_front()}, {24'h0, rdData}, 0); // byte value
		end
		if (burstDone === 1'b1 && bq.size() > 0) begin
			e = bq.pop_front();
			chk("burst channel", {28'h0, e[31:28]}, {28'h0, burstChan}, 0); // routed channel
			if (e[27:0] != 28'hFFFFFFF)
				chk("burst length", {4'h0, e[27:0]}, burstLen, 3); // message length
		end
	end
	initial begin
		#(95000 * 25);
		n_fail++;
		$display("watchdog expired");
		summarize();
	end
	// ====
	// Main sequence
	initial begin
		seed = 32'h2A;
		rst = 1'b1;
		ce = 1'b1;
		cmdValid = 1'b0;
		cmd = '0;
		n_fail = 0;
		samples_checked = 0;
		repeat (4) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		for (i = 8'h13; i <= 8'h17; i++)
			rd(1'b0, i[5:0], 8'h00); // zero after reset
		$display("test reset values done");
		for (i = 8'h13; i <= 8'h16; i++) begin
			v = rnd();
			req(1'b1, 1'b0, i[5:0], v[7:0]);
			rd(1'b0, i[5:0], v[7:0]); // field readback
		end
		req(1'b1, 1'b0, `FSKC_ADDR_CTRL, 8'hF4);
		rd(1'b0, `FSKC_ADDR_CTRL, 8'h34); // control readback
		req(1'b1, 1'b0, 6'h00, 8'h5A);
		rd(1'b0, 6'h00, 8'h00); // unmapped reads zero
		req(1'b1, 1'b0, `FSKC_ADDR_CTRL, 8'h01);
		repeat (8) @(negedge clock);
		chk("launch while off", 32'h0, {28'h0, chanActive}, 0); // refused launch
		$display("test registers done");
		for (i = 8'h00; i < 8'h40; i++) begin
			v = rnd();
			store[i[5:0]] = v[7:0];
			req(1'b1, 1'b1, i[5:0], v[7:0]);
		end
		for (i = 8'h00; i < 8'h40; i++)
			rd(1'b1, i[5:0], store[i[5:0]]); // store readback
		$display("test data store done");
		for (i = 8'h00; i < 8'h04; i++) begin
			v = rnd();
			send(i[1:0], i[0], {6'h0, v[1:0]} + 8'h01, {6'h0, v[3:2]}, {6'h0, v[5:4]},
				{6'h0, v[7:6]}); // full message
		end
		send(2'h2, 1'b0, 8'h01, 8'h00, 8'hC8, 8'h00); // count clamped
		send(2'h1, 1'b1, 8'h00, 8'h03, 8'h00, 8'h00); // no data bytes
		$display("test messages done");
		bq.push_back({4'h8, 28'hFFFFFFF});
		req(1'b1, 1'b0, `FSKC_ADDR_BYTES, 8'h40);
		req(1'b1, 1'b0, `FSKC_ADDR_CTRL, 8'h39);
		repeat (100) @(negedge clock);
		req(1'b1, 1'b0, `FSKC_ADDR_CTRL, 8'h30);
		repeat (8) @(negedge clock);
		chk("abort silent", 32'h0, {28'h0, chanActive}, 0); // output stopped
		rd(1'b0, `FSKC_ADDR_CTRL, 8'h30); // launch dropped
		$display("test abort done");
		req(1'b1, 1'b0, `FSKC_ADDR_SEIZE, 8'h01);
		req(1'b1, 1'b0, `FSKC_ADDR_BYTES, 8'h00);
		req(1'b1, 1'b0, `FSKC_ADDR_MARK, 8'h00);
		// hold set for segment, cleared after last
		for (i = 8'h00; i < 8'h02; i++) begin
			bq.push_back({4'h1, 28'hFFFFFFF});
			req(1'b1, 1'b0, `FSKC_ADDR_CTRL, {5'b00001, i[0], 2'b11});
			repeat (80) @(negedge clock);
			rd(1'b0, `FSKC_ADDR_CTRL, {5'b00001, i[0], 2'b10}); // cleared under hold
			chk("hold active", 32'h1, {28'h0, chanActive}, 0); // ones held
			k = 0;
			while (edgeCnt < 8'h02 && k < 40000) begin
				@(negedge clock);
				k++;
			end
			chk("mark half period", i[0] ? 32'd15385 : 32'd16667, halfLen, 160); // mark tone
			req(1'b1, 1'b0, `FSKC_ADDR_CTRL, {5'b00001, i[0], 2'b00});
			repeat (8) @(negedge clock);
			chk("hold muted", 32'h0, {28'h0, chanActive}, 0); // muted
			req(1'b1, 1'b0, `FSKC_ADDR_CTRL, {5'b00001, i[0], 2'b10});
			repeat (50) @(negedge clock);
			chk("hold not resumed", 32'h0, {28'h0, chanActive}, 0); // no resume
		end
		req(1'b1, 1'b0, `FSKC_ADDR_CTRL, 8'h00);
		repeat (10) @(negedge clock);
		$display("test hold done");
		summarize();
	end
endmodule : fskc_sequencer_tb
`default_nettype wire
